// [rtl/crpm_pkg.sv]
package crpm_pkg;
  // Clock and timer figures
  localparam int CLK_MHZ = 10;
  localparam int IPG_NS  = 960;
  localparam int RM_NS   = 1120;
  localparam logic [3:0] IPG_CYC = 4'((IPG_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] RM_CYC  = 4'((RM_NS * CLK_MHZ + 999) / 1000);

  // MII nibble codes and index of the last preamble nibble of 5
  localparam logic [3:0] PRE_NIB  = 4'h5;
  localparam logic [3:0] SFD_NIB  = 4'hd;
  localparam logic [3:0] PRE_LAST = 4'he;

  // Sizes
  localparam int NEP    = 32;
  localparam int SEQ_W  = 14;
  localparam int BUF_AW = 11;
  localparam int LEN_W  = 12;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_FRAG   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_LINK   = 4'hc;

  // Field positions
  localparam int CTRL_AGG_BIT = 0;
  localparam int CTRL_BLK_BIT = 1;
  localparam int CTRL_EP_LSB  = 8;
  localparam int FRAG_MIN_LSB = 0;
  localparam int FRAG_MAX_LSB = 16;
  localparam int ST_RXAV_BIT  = 0;
  localparam int ST_TXAV_BIT  = 1;
  localparam int ST_CAP_BIT   = 2;
  localparam int ST_SEQ_LSB   = 16;

  // Reset values
  localparam logic [11:0] FRAG_MIN_RST = 12'h040;
  localparam logic [11:0] FRAG_MAX_RST = 12'h200;
  localparam logic [4:0]  EP_SEL_RST   = 5'h00;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_CAPT = 4'h2,
    TX_SEND = 4'h4,
    TX_WAIT = 4'h8
  } crpm_tx_e;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_PRE  = 4'h2,
    RX_DATA = 4'h4,
    RX_IPG  = 4'h8
  } crpm_rx_e;
endpackage : crpm_pkg

// [rtl/crpm_top.sv]
`timescale 1ns/1ps
module crpm_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  mii_txd,
  input  wire logic        mii_tx_en,
  output logic      [3:0]  mii_rxd,
  output logic             mii_rx_dv,
  output logic             mii_rx_er,
  output logic             mii_crs,
  output logic             mii_col,
  input  wire logic        aggregation_capable,
  input  wire logic [31:0] convergence_link_up,
  output logic      [7:0]  line_data,
  output logic             line_valid,
  input  wire logic        line_ready,
  output logic             line_first,
  output logic             line_last,
  output logic      [4:0]  line_ep,
  output logic             line_abort,
  input  wire logic [7:0]  lrx_data,
  input  wire logic        lrx_valid,
  input  wire logic        lrx_last,
  input  wire logic        lrx_crc_bad,
  output logic             rx_frame_available,
  output logic             tx_buffer_available,
  output logic             frame_handoff_done
);
  localparam int AW = crpm_pkg::BUF_AW;
  localparam int LW = crpm_pkg::LEN_W;

  crpm_pkg::crpm_tx_e tx_st_r;
  crpm_pkg::crpm_rx_e rx_st_r;
  logic                 waitreq_r, agg_on_r, rx_block_r;
  logic [4:0]           ep_sel_r, ep_r;
  logic [11:0]          min_r, max_r;
  logic [7:0]           tx_mem [0:(1<<AW)-1];
  logic [9:0]           rx_mem [0:(1<<AW)-1];
  logic [LW-1:0]        wr_ptr_r, rd_ptr_r, len_r, frag_rem_r, rem, flen;
  logic [1:0]           hdr_cnt_r;
  logic                 sfd_r, nib_hi_r, link_ok_r, sop_r, eop_r;
  logic [3:0]           nib_lo_r, rm_cnt_r, rx_cnt_r;
  logic [13:0]          seq_r;
  logic                 agg, tx_we, unit_busy, out_free;
  logic [5:0]           pick;
  logic [AW-1:0]        rx_wp_r, rx_rp_r;
  logic [11:0]          frm_cnt_r, frm_cnt_nxt;
  logic                 rx_we, rx_re, rx_full, crs_tx, crs_rx;
  logic [9:0]           rx_word;
  logic                 nib_hi_rx;

  assign agg = agg_on_r & aggregation_capable;
  assign avs_waitrequest = waitreq_r;

  // Avalon handshake: one wait cycle, then the access completes
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      waitreq_r <= 1'b1;
    else
      waitreq_r <= !((avs_read || avs_write) && waitreq_r);
  end

  // Read data captured while waitrequest is still high
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && waitreq_r)
    begin
      avs_readdata <= 32'h0000_0000;
      case (avs_address)
        crpm_pkg::OFS_CTRL:
        begin
          avs_readdata[crpm_pkg::CTRL_AGG_BIT] <= agg_on_r;
          avs_readdata[crpm_pkg::CTRL_BLK_BIT] <= rx_block_r;
          avs_readdata[crpm_pkg::CTRL_EP_LSB +: 5] <= ep_sel_r;
        end
        crpm_pkg::OFS_FRAG:
        begin
          avs_readdata[crpm_pkg::FRAG_MIN_LSB +: 12] <= min_r;
          avs_readdata[crpm_pkg::FRAG_MAX_LSB +: 12] <= max_r;
        end
        crpm_pkg::OFS_STATUS:
        begin
          avs_readdata[crpm_pkg::ST_RXAV_BIT] <= rx_frame_available;
          avs_readdata[crpm_pkg::ST_TXAV_BIT] <= tx_buffer_available;
          avs_readdata[crpm_pkg::ST_CAP_BIT] <= aggregation_capable;
          avs_readdata[crpm_pkg::ST_SEQ_LSB +: 14] <= seq_r;
        end
        crpm_pkg::OFS_LINK:
          avs_readdata <= convergence_link_up;
        default:
          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers, written on the completing cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      agg_on_r   <= 1'b0;
      rx_block_r <= 1'b0;
      ep_sel_r   <= crpm_pkg::EP_SEL_RST;
      min_r      <= crpm_pkg::FRAG_MIN_RST;
      max_r      <= crpm_pkg::FRAG_MAX_RST;
    end
    else if (avs_write && !waitreq_r)
    begin
      case (avs_address)
        crpm_pkg::OFS_CTRL:
        begin
          agg_on_r   <= avs_writedata[crpm_pkg::CTRL_AGG_BIT];
          rx_block_r <= avs_writedata[crpm_pkg::CTRL_BLK_BIT];
          ep_sel_r   <= avs_writedata[crpm_pkg::CTRL_EP_LSB +: 5];
        end
        crpm_pkg::OFS_FRAG:
        begin
          min_r <= avs_writedata[crpm_pkg::FRAG_MIN_LSB +: 12];
          max_r <= avs_writedata[crpm_pkg::FRAG_MAX_LSB +: 12];
        end
        default: ;
      endcase
    end
  end

  // Next active endpoint after the last one used, round robin
  function automatic logic [5:0] crpm_rr(input logic [31:0] up,
                                         input logic [4:0]  last);
    logic [5:0] res;
    logic [4:0] k;
    res = 6'h00;
    for (int i = crpm_pkg::NEP; i >= 1; i--)
    begin
      k = last + 5'(i);
      if (up[k])
        res = {1'b1, k};
    end
    return res;
  endfunction : crpm_rr

  assign pick = crpm_rr(convergence_link_up, ep_r);

  // Fragment length: max, or shortened so the tail is not below min
  assign rem = len_r - rd_ptr_r;
  always_comb
  begin
    if (rem <= max_r)
      flen = rem;
    else if ((rem - max_r) < min_r)
      flen = rem - min_r;
    else
      flen = max_r;
  end

  assign tx_we     = (tx_st_r == crpm_pkg::TX_CAPT) && mii_tx_en && sfd_r
                     && nib_hi_r && (wr_ptr_r < LW'(1 << AW));
  assign unit_busy = (hdr_cnt_r != 2'h0) || (frag_rem_r != '0) || line_valid;
  assign out_free  = !line_valid || line_ready;
  assign crs_tx    = (tx_st_r != crpm_pkg::TX_IDLE);

  // Transmit buffer: bytes assembled low nibble first
  always_ff @(posedge clk)
  begin
    if (tx_we)
      tx_mem[wr_ptr_r[AW-1:0]] <= {mii_txd, nib_lo_r};
  end

  // Transmit rate matching, fragmentation and line output
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_st_r <= crpm_pkg::TX_IDLE;
      {wr_ptr_r, rd_ptr_r, len_r, frag_rem_r} <= '0;
      {sfd_r, nib_hi_r, link_ok_r, sop_r, eop_r} <= 5'h00;
      hdr_cnt_r <= 2'h0;
      nib_lo_r <= 4'h0;
      rm_cnt_r <= 4'h0;
      seq_r <= 14'h0000;
      ep_r <= 5'h00;
      line_data <= 8'h00;
      {line_valid, line_first, line_last, line_abort} <= 4'h0;
      line_ep <= 5'h00;
    end
    else
    begin
      line_abort <= 1'b0;
      case (tx_st_r)
        crpm_pkg::TX_IDLE:
        begin
          if (mii_tx_en)
          begin
            tx_st_r <= crpm_pkg::TX_CAPT;
            {sfd_r, nib_hi_r} <= 2'h0;
            wr_ptr_r <= '0;
            link_ok_r <= agg || convergence_link_up[ep_sel_r];
          end
        end
        crpm_pkg::TX_CAPT:
        begin
          if (!agg && !convergence_link_up[ep_sel_r])
            link_ok_r <= 1'b0;
          if (!mii_tx_en)
          begin
            len_r <= wr_ptr_r;
            rd_ptr_r <= '0;
            {frag_rem_r, hdr_cnt_r} <= '0;
            tx_st_r <= crpm_pkg::TX_SEND;
          end
          else if (!sfd_r)
            sfd_r <= (mii_txd == crpm_pkg::SFD_NIB);
          else if (!nib_hi_r)
          begin
            nib_lo_r <= mii_txd;
            nib_hi_r <= 1'b1;
          end
          else
          begin
            nib_hi_r <= 1'b0;
            if (tx_we)
              wr_ptr_r <= wr_ptr_r + LW'(1);
          end
        end
        crpm_pkg::TX_SEND:
        begin
          if (unit_busy && !convergence_link_up[ep_r])
          begin
            line_abort <= 1'b1;
            line_valid <= 1'b0;
            rm_cnt_r <= crpm_pkg::RM_CYC - 4'h1;
            tx_st_r <= crpm_pkg::TX_WAIT;
          end
          else if (out_free)
          begin
            line_ep <= ep_r;
            line_first <= 1'b0;
            line_last <= 1'b0;
            if (hdr_cnt_r == 2'h2)
            begin
              line_data <= seq_r[13:6];
              line_valid <= 1'b1;
              line_first <= 1'b1;
              hdr_cnt_r <= 2'h1;
            end
            else if (hdr_cnt_r == 2'h1)
            begin
              line_data <= {seq_r[5:0], sop_r, eop_r};
              hdr_cnt_r <= 2'h0;
            end
            else if (frag_rem_r != '0)
            begin
              line_data <= tx_mem[rd_ptr_r[AW-1:0]];
              line_valid <= 1'b1;
              line_first <= !agg && (rd_ptr_r == '0);
              line_last <= (frag_rem_r == LW'(1));
              rd_ptr_r <= rd_ptr_r + LW'(1);
              frag_rem_r <= frag_rem_r - LW'(1);
            end
            else
            begin
              line_valid <= 1'b0;
              if (rd_ptr_r == len_r || (!agg && !link_ok_r))
              begin
                rm_cnt_r <= crpm_pkg::RM_CYC - 4'h1;
                tx_st_r <= crpm_pkg::TX_WAIT;
              end
              else if (!agg)
              begin
                ep_r <= ep_sel_r;
                frag_rem_r <= len_r;
              end
              else if (pick[5])
              begin
                ep_r <= pick[4:0];
                frag_rem_r <= flen;
                sop_r <= (rd_ptr_r == '0);
                eop_r <= (flen == rem);
                seq_r <= seq_r + 14'h0001;
                hdr_cnt_r <= 2'h2;
              end
            end
          end
        end
        crpm_pkg::TX_WAIT:
        begin
          line_valid <= 1'b0;
          if (rm_cnt_r == 4'h0)
            tx_st_r <= crpm_pkg::TX_IDLE;
          else
            rm_cnt_r <= rm_cnt_r - 4'h1;
        end
        default: tx_st_r <= crpm_pkg::TX_IDLE;
      endcase
    end
  end

  // Receive FIFO from the convergence side, whole frames
  assign rx_full = (rx_wp_r + AW'(1)) == rx_rp_r;
  assign rx_we   = lrx_valid && !rx_full;
  assign rx_word = rx_mem[rx_rp_r];
  always_ff @(posedge clk)
  begin
    if (rx_we)
      rx_mem[rx_wp_r] <= {lrx_crc_bad, lrx_last, lrx_data};
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rx_wp_r <= '0;
    else if (rx_we)
      rx_wp_r <= rx_wp_r + AW'(1);
  end

  // Count of complete frames held in the receive FIFO
  always_comb
  begin
    frm_cnt_nxt = frm_cnt_r;
    if (rx_we && lrx_last)
      frm_cnt_nxt = frm_cnt_nxt + 12'h001;
    if (rx_re && rx_word[8])
      frm_cnt_nxt = frm_cnt_nxt - 12'h001;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      frm_cnt_r <= 12'h000;
      rx_frame_available <= 1'b0;
      tx_buffer_available <= 1'b0;
    end
    else
    begin
      frm_cnt_r <= frm_cnt_nxt;
      rx_frame_available <= (frm_cnt_nxt != 12'h000);
      tx_buffer_available <= (tx_st_r == crpm_pkg::TX_IDLE);
    end
  end

  assign rx_re  = (rx_st_r == crpm_pkg::RX_DATA) && nib_hi_rx;
  assign crs_rx = (rx_st_r == crpm_pkg::RX_PRE) ||
                  (rx_st_r == crpm_pkg::RX_DATA);

  // Receive rate matching: preamble, nibbles to MAC, gap
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rx_st_r <= crpm_pkg::RX_IDLE;
      rx_rp_r <= '0;
      rx_cnt_r <= 4'h0;
      nib_hi_rx <= 1'b0;
      mii_rxd <= 4'h0;
      {mii_rx_dv, mii_rx_er, frame_handoff_done} <= 3'h0;
    end
    else
    begin
      frame_handoff_done <= 1'b0;
      case (rx_st_r)
        crpm_pkg::RX_IDLE:
        begin
          if (frm_cnt_r != 12'h000 && !(rx_block_r && mii_tx_en))
          begin
            rx_st_r <= crpm_pkg::RX_PRE;
            rx_cnt_r <= 4'h0;
            mii_rxd <= crpm_pkg::PRE_NIB;
            mii_rx_dv <= 1'b1;
          end
        end
        crpm_pkg::RX_PRE:
        begin
          rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_cnt_r == crpm_pkg::PRE_LAST)
            mii_rxd <= crpm_pkg::SFD_NIB;
          else if (rx_cnt_r == crpm_pkg::PRE_LAST + 4'h1)
          begin
            rx_st_r <= crpm_pkg::RX_DATA;
            mii_rxd <= rx_word[3:0];
            mii_rx_er <= rx_word[9] && rx_word[8];
          end
        end
        crpm_pkg::RX_DATA:
        begin
          nib_hi_rx <= !nib_hi_rx;
          if (!nib_hi_rx)
            mii_rxd <= rx_word[7:4];
          else
          begin
            rx_rp_r <= rx_rp_r + AW'(1);
            if (rx_word[8])
            begin
              {mii_rx_dv, mii_rx_er} <= 2'h0;
              mii_rxd <= 4'h0;
              frame_handoff_done <= 1'b1;
              rx_cnt_r <= crpm_pkg::IPG_CYC - 4'h1;
              rx_st_r <= crpm_pkg::RX_IPG;
            end
            else
            begin
              mii_rxd <= rx_mem[rx_rp_r + AW'(1)][3:0];
              mii_rx_er <= rx_mem[rx_rp_r + AW'(1)][9] &&
                           rx_mem[rx_rp_r + AW'(1)][8];
            end
          end
        end
        crpm_pkg::RX_IPG:
        begin
          if (rx_cnt_r == 4'h0)
            rx_st_r <= crpm_pkg::RX_IDLE;
          else
            rx_cnt_r <= rx_cnt_r - 4'h1;
        end
        default: rx_st_r <= crpm_pkg::RX_IDLE;
      endcase
    end
  end

  // Carrier sense and collision toward the MAC
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      {mii_crs, mii_col} <= 2'h0;
    else
    begin
      mii_crs <= crs_tx || crs_rx;
      mii_col <= 1'b0;
    end
  end

  // Cycles spent in the two timed states, read only by checks
  logic [4:0] wait_len_r, gap_len_r;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      {wait_len_r, gap_len_r} <= 10'h000;
    else
    begin
      wait_len_r <= (tx_st_r == crpm_pkg::TX_WAIT) ?
                    wait_len_r + 5'h01 : 5'h00;
      gap_len_r <= (rx_st_r == crpm_pkg::RX_IPG) ? gap_len_r + 5'h01 : 5'h00;
    end
  end

  chk_col_low: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 !mii_col) else $error("collision not low");
  chk_crs_or: assert property (@(posedge clk) disable iff (!reset_n)
    (crs_tx || crs_rx) |=> mii_crs) else $error("crs missing");
  chk_rm_time: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_st_r == crpm_pkg::TX_WAIT) ##1 (tx_st_r == crpm_pkg::TX_IDLE)
    |-> $past(wait_len_r) == 5'(crpm_pkg::RM_CYC) - 5'h01)
    else $error("wait length wrong");
  chk_gap_time: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_st_r == crpm_pkg::RX_IPG) ##1 (rx_st_r == crpm_pkg::RX_IDLE)
    |-> $past(gap_len_r) == 5'(crpm_pkg::IPG_CYC) - 5'h01)
    else $error("gap length wrong");
  chk_rx_block: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_st_r == crpm_pkg::RX_IDLE && rx_block_r && mii_tx_en)
    |=> !mii_rx_dv) else $error("rx during tx");
  chk_preamble: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(mii_rx_dv) |-> (mii_rxd == crpm_pkg::PRE_NIB) [*8])
    else $error("preamble wrong");
  chk_done_end: assert property (@(posedge clk) disable iff (!reset_n)
    frame_handoff_done |-> !mii_rx_dv && $past(mii_rx_dv) ##1
    !frame_handoff_done) else $error("done flag wrong");
  chk_seq_step: assert property (@(posedge clk) disable iff (!reset_n)
    (hdr_cnt_r == 2'h2 && $past(hdr_cnt_r) == 2'h0)
    |-> seq_r == $past(seq_r) + 14'h0001) else $error("sequence step");
  chk_link_abort: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_st_r == crpm_pkg::TX_SEND && unit_busy && !convergence_link_up[ep_r])
    |=> line_abort && !line_valid) else $error("no abort");
  chk_frag_max: assert property (@(posedge clk) disable iff (!reset_n)
    (agg && hdr_cnt_r == 2'h2) |-> frag_rem_r <= max_r)
    else $error("fragment too long");
endmodule : crpm_top

// [sim/crpm_line_model.sv]
`timescale 1ns/1ps
// Endpoint side: stalls the line sender and feeds received frames
module crpm_line_model (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      line_ready,
  output logic [7:0] lrx_data,
  output logic      lrx_valid,
  output logic      lrx_last,
  output logic      lrx_crc_bad
);
  logic [1:0] stall_r = 2'h0;

  // Quiet outputs at time zero
  initial
  begin
    line_ready  = 1'b0;
    lrx_data    = 8'h00;
    lrx_valid   = 1'b0;
    lrx_last    = 1'b0;
    lrx_crc_bad = 1'b0;
  end

  // Accept three bytes of four so the sender must hold its data
  always @(posedge clk)
  begin
    stall_r    <= reset_n ? stall_r + 2'h1 : 2'h0;
    line_ready <= reset_n && (stall_r != 2'h3);
  end

  // One byte per cycle; check flag only with the last byte
  task automatic send(input logic [7:0] b[$], input logic bad);
    foreach (b[i])
    begin
      @(posedge clk);
      lrx_data    <= b[i];
      lrx_valid   <= 1'b1;
      lrx_last    <= (i == b.size() - 1);
      lrx_crc_bad <= bad && (i == b.size() - 1);
    end
    @(posedge clk);
    lrx_valid   <= 1'b0;
    lrx_last    <= 1'b0;
    lrx_crc_bad <= 1'b0;
    lrx_data    <= ~lrx_data; // Released bus shows no stale byte
  endtask : send
endmodule : crpm_line_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, reset_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic        avs_waitrequest, mii_tx_en = 1'b0;
  logic [3:0]  mii_txd = 4'h0, mii_rxd;
  logic        mii_rx_dv, mii_rx_er, mii_crs, mii_col, dv_q = 1'b0;
  logic        aggregation_capable = 1'b1;
  logic [31:0] convergence_link_up = 32'hffff_ffff;
  logic [7:0]  line_data, lrx_data;
  logic        line_valid, line_ready, line_first, line_last, line_abort;
  logic [4:0]  line_ep;
  logic        lrx_valid, lrx_last, lrx_crc_bad;
  logic        rx_frame_available, tx_buffer_available, frame_handoff_done;
  int          fail_count = 0, compares = 0;
  int          cyc = 0, fall_at = 0, gap = 0, done_n = 0, abort_n = 0;
  logic [14:0] lq[$];
  logic [4:0]  rq[$];

  crpm_top crpm_top_inst (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mii_txd(mii_txd),
    .mii_tx_en(mii_tx_en), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv),
    .mii_rx_er(mii_rx_er), .mii_crs(mii_crs), .mii_col(mii_col),
    .aggregation_capable(aggregation_capable),
    .convergence_link_up(convergence_link_up), .line_data(line_data),
    .line_valid(line_valid), .line_ready(line_ready),
    .line_first(line_first), .line_last(line_last), .line_ep(line_ep),
    .line_abort(line_abort), .lrx_data(lrx_data), .lrx_valid(lrx_valid),
    .lrx_last(lrx_last), .lrx_crc_bad(lrx_crc_bad),
    .rx_frame_available(rx_frame_available),
    .tx_buffer_available(tx_buffer_available),
    .frame_handoff_done(frame_handoff_done));

  crpm_line_model crpm_line_model_inst (.clk(clk), .reset_n(reset_n),
    .line_ready(line_ready), .lrx_data(lrx_data), .lrx_valid(lrx_valid),
    .lrx_last(lrx_last), .lrx_crc_bad(lrx_crc_bad));

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic print_verdict;
    $display("compares %0d, fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // Record accepted line bytes, receive nibbles, gaps and pulses
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    dv_q <= mii_rx_dv;
    if (line_valid === 1'b1 && line_ready === 1'b1)
      lq.push_back({line_ep, line_first, line_last, line_data});
    if (mii_rx_dv === 1'b1)
      rq.push_back({mii_rx_er, mii_rxd});
    if (dv_q === 1'b1 && mii_rx_dv === 1'b0)
      fall_at <= cyc;
    if (dv_q === 1'b0 && mii_rx_dv === 1'b1)
      gap <= cyc - fall_at;
    if (frame_handoff_done === 1'b1)
      done_n <= done_n + 1;
    if (line_abort === 1'b1)
      abort_n <= abort_n + 1;
    if (reset_n === 1'b1)
    begin
      chk("collision", 1'b0, mii_col);
      // Registered carrier trails the first receive nibble by one clock
      if (mii_rx_dv === 1'b1 && dv_q === 1'b1)
        chk("carrier in receive", 1'b1, mii_crs);
    end
  end

  // Avalon access: hold request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_writedata <= wd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100)
    begin
      chk("bus answer", 1'b0, avs_waitrequest);
      print_verdict();
    end
  endtask : bus

  // MAC frame: preamble, delimiter, then bytes low nibble first
  task automatic mac_send(input logic [7:0] b[$]);
    @(posedge clk);
    mii_tx_en <= 1'b1;
    for (int i = 0; i < 16 + 2 * b.size(); i++)
    begin
      mii_txd <= i < 15 ? 4'h5 : i == 15 ? 4'hd :
                 i % 2 ? b[(i - 16) / 2][7:4] : b[(i - 16) / 2][3:0];
      @(posedge clk);
    end
    mii_tx_en <= 1'b0;
    mii_txd   <= ~mii_txd;
  endtask : mac_send

  // Wait for nr receive nibbles and carrier to drop, bounded
  task automatic settle(input int nr);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((rq.size() < nr || mii_crs !== 1'b0) && n < 3000);
    if (n >= 3000)
    begin
      chk("settle", 1'b0, mii_crs);
      print_verdict();
    end
  endtask : settle

  // Compare line bytes as {first, last, data} and their endpoint
  task automatic chk_line(input logic [9:0] e[$], input logic [4:0] ep,
                          input logic any_ep);
    chk("line count", e.size(), lq.size());
    foreach (e[i])
      if (i < lq.size())
      begin
        chk("line byte", e[i], lq[i][9:0]);
        if (any_ep)
          chk("endpoint up", 1'b1, convergence_link_up[lq[i][14:10]]);
        else
          chk("endpoint", ep, lq[i][14:10]);
      end
    lq.delete();
  endtask : chk_line

  // Compare one received frame as seen on the MII
  task automatic chk_rx(input logic [7:0] b[$], input logic bad);
    int n;
    n = 2 * b.size();
    for (int i = 0; i < 16 + n; i++)
      chk("receive nibble", i < 15 ? 5'h05 : i == 15 ? 5'h0d :
          {bad && i >= 14 + n, i % 2 ? b[(i - 16) / 2][7:4] :
           b[(i - 16) / 2][3:0]}, rq.pop_front());
  endtask : chk_rx

  task automatic test_regs;
    bus(1'b0, 4'h8, 32'h0);
    chk("status reset", 32'h0000_0006, rd);
    bus(1'b0, 4'h4, 32'h0);
    chk("fragment limits reset", 32'h0200_0040, rd);
    bus(1'b0, 4'hc, 32'h0);
    chk("link status", 32'hffff_ffff, rd);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped read", 32'h0, rd);
  endtask : test_regs

  task automatic test_whole;
    bus(1'b1, 4'h0, 32'h0000_0500);
    mac_send('{8'h11, 8'h22, 8'h33, 8'h44});
    chk("carrier while busy", 1'b1, mii_crs);
    chk("buffer busy", 1'b0, tx_buffer_available);
    settle(0);
    chk("buffer free", 1'b1, tx_buffer_available);
    chk_line('{10'h211, 10'h022, 10'h033, 10'h144}, 5'h05, 1'b0);
    fork
      mac_send('{8'h55, 8'h66, 8'h77, 8'h88});
      begin
        repeat (20) @(posedge clk);
        convergence_link_up[5] <= 1'b0;
      end
    join
    settle(0);
    chk("dropped frame", 0, lq.size());
    lq.delete();
    convergence_link_up <= 32'hffff_ffff;
  endtask : test_whole

  task automatic test_frag;
    convergence_link_up <= 32'h0000_0084;
    bus(1'b1, 4'h4, 32'h0004_0001);
    bus(1'b1, 4'h0, 32'h0000_0001);
    mac_send('{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5});
    settle(0);
    chk_line('{10'h200, 10'h006, 10'h0a0, 10'h0a1, 10'h0a2, 10'h1a3,
               10'h200, 10'h009, 10'h0a4, 10'h1a5}, 5'h0, 1'b1);
    mac_send('{8'hb0, 8'hb1});
    settle(0);
    chk_line('{10'h200, 10'h00f, 10'h0b0, 10'h1b1}, 5'h0, 1'b1);
    bus(1'b0, 4'h8, 32'h0);
    chk("sequence count", 32'h0003_0006, rd);
    // Endpoint links drop while the first fragment header is on the line
    mac_send('{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5});
    repeat (3) @(posedge clk);
    convergence_link_up <= 32'h0000_0000;
    settle(0);
    chk("abort pulses", 1, abort_n);
    lq.delete();
    convergence_link_up <= 32'hffff_ffff;
    bus(1'b1, 4'h0, 32'h0);
  endtask : test_frag

  task automatic test_rx;
    int d0;
    d0 = done_n;
    rq.delete();
    // Block mode: the first frame waits while the MAC transmits
    bus(1'b1, 4'h0, 32'h0000_0002);
    mii_tx_en <= 1'b1;
    crpm_line_model_inst.send('{8'hc1, 8'hc2, 8'hc3}, 1'b1);
    repeat (30) @(posedge clk);
    chk("receive held", 0, rq.size());
    chk("frame available", 1'b1, rx_frame_available);
    mii_tx_en <= 1'b0;
    crpm_line_model_inst.send('{8'hd4}, 1'b0);
    settle(40);
    chk_rx('{8'hc1, 8'hc2, 8'hc3}, 1'b1);
    chk_rx('{8'hd4}, 1'b0);
    chk("handoff pulses", d0 + 2, done_n);
    chk("gap ok", 1'b1, gap >= int'(crpm_pkg::IPG_CYC));
    chk("fifo drained", 1'b0, rx_frame_available);
  endtask : test_rx

  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    test_regs();
    test_whole();
    test_frag();
    test_rx();
    print_verdict();
  end
endmodule : testbench
